// ### core/ramp_seg_regs.svh
// Constants for the ramp segment sequencer: field widths, reset values and codes.
// Assumes inclusion by bare name from the package and modules.
`ifndef RAMP_SEG_REGS_SVH
`define RAMP_SEG_REGS_SVH
`define SEG_COUNT 8
`define SEG_IDX_W 3
`define SEG_INC_W 30
`define SEG_LEN_W 16
`define ACC_W 33
`define SEG_FIRST 3'h0
`define ADV_LENGTH 2'h0
`define ADV_EVENT_A 2'h1
`define ADV_EVENT_B 2'h2
`define ADV_EVENT_C 2'h3
`define HALF_RATE_TICKS 1'h1
`endif

// ### core/ramp_seg_pkg.sv
// Types shared by the ramp segment sequencer files.
// Assumes the constants header is on the include path.
`include "ramp_seg_regs.svh"
package ramp_seg_pkg;
  typedef enum logic [1:0] {ADV_LEN, ADV_A, ADV_B, ADV_C} advance_src_t;
  typedef enum logic {SEQ_IDLE, SEQ_RUN} seq_state_t;
endpackage

// ### core/seg_table.sv
// Eight-entry table of per-segment settings, written one segment at a time.
// Assumes writes come from configuration logic on the same clock.
`timescale 1ns/1ps
`include "ramp_seg_regs.svh"
module seg_table
  import ramp_seg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic wr_en,
  input wire logic [2:0] wr_idx,
  input wire logic [29:0] wr_increment,
  input wire logic [15:0] wr_length,
  input wire logic wr_half_rate,
  input wire logic wr_fast_settle,
  input wire logic [1:0] wr_marker_bits,
  input wire logic wr_accum_clear,
  input wire logic [1:0] wr_advance_source,
  input wire logic [2:0] wr_successor,
  input wire logic [2:0] rd_idx,
  output logic [29:0] rd_increment,
  output logic [15:0] rd_length,
  output logic rd_half_rate,
  output logic rd_fast_settle,
  output logic [1:0] rd_marker_bits,
  output logic rd_accum_clear,
  output logic [1:0] rd_advance_source,
  output logic [2:0] rd_successor
);
  localparam int ENTRY_W = 30 + 16 + 1 + 1 + 2 + 1 + 2 + 3;
  logic [ENTRY_W-1:0] mem_r [`SEG_COUNT];
  logic [ENTRY_W-1:0] mem_nxt [`SEG_COUNT];

  always_comb begin
    for (int i = 0; i < `SEG_COUNT; i++) begin
      mem_nxt[i] = mem_r[i];
    end
    if (wr_en) begin
      mem_nxt[wr_idx] = {wr_increment, wr_length, wr_half_rate, wr_fast_settle,
                         wr_marker_bits, wr_accum_clear, wr_advance_source, wr_successor};
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < `SEG_COUNT; i++) begin
        mem_r[i] <= '0;
      end
    end else begin
      mem_r <= mem_nxt;
    end
  end

  assign {rd_increment, rd_length, rd_half_rate, rd_fast_settle, rd_marker_bits,
          rd_accum_clear, rd_advance_source, rd_successor} = mem_r[rd_idx];
endmodule

// ### core/ramp_segment_control.sv
// Segment sequencer for a piecewise-linear ramp: steps through eight segments on
// phase-compare ticks or trigger events and drives the ramp accumulator, markers and fast-settle.
// Assumes phase_compare_tick is a one-cycle pulse on ref_clk and trigger events come
// from pins, so they are synchronised here.
`timescale 1ns/1ps
`include "ramp_seg_regs.svh"
// Summary of operation
// - an active segment adds its signed 30-bit increment each tick for length ticks, 0 meaning 65536.
// - a half-rate segment spends two phase-compare cycles per tick, otherwise one.
// - a fast-settle segment asserts the single fast_settle_en output while it runs.
// - the segment's two marker bits drive the two marker outputs during the segment.
// - a segment with accumulator clear zeroes the accumulator on entry.
// - the advance selector picks length expiry or event A, B or C to leave a segment.
// - on leaving, the sequencer goes to the segment named by the successor field.
// - every field is held separately for each of the eight segments.
module ramp_segment_control
  import ramp_seg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic ramp_run,
  input wire logic phase_compare_tick,
  input wire logic event_source_a,
  input wire logic event_source_b,
  input wire logic event_source_c,
  input wire logic cfg_wr_en,
  input wire logic [2:0] cfg_segment,
  input wire logic [29:0] segment_increment,
  input wire logic [15:0] segment_length,
  input wire logic segment_half_rate,
  input wire logic segment_fast_settle,
  input wire logic [1:0] segment_marker_bits,
  input wire logic segment_accum_clear,
  input wire logic [1:0] segment_advance_source,
  input wire logic [2:0] segment_successor,
  output logic [32:0] ramp_accum,
  output logic [2:0] active_segment,
  output logic fast_settle_en,
  output logic marker_out_low,
  output logic marker_out_high
);
  seq_state_t state_r, state_nxt;
  logic [2:0] seg_r, seg_nxt;
  logic [16:0] ticks_r, ticks_nxt;
  logic pre_r, pre_nxt;
  logic [32:0] acc_r, acc_nxt;
  logic fs_r, fs_nxt;
  logic [1:0] mk_r, mk_nxt;
  logic [2:0] sa_r, sb_r, sc_r;
  logic [2:0] sa_nxt, sb_nxt, sc_nxt;
  logic ev_a_r, ev_b_r, ev_c_r;
  logic ev_a_nxt, ev_b_nxt, ev_c_nxt;
  logic [2:0] rd_idx;
  logic [29:0] t_inc;
  logic [15:0] t_len;
  logic t_half, t_fs, t_clr;
  logic [1:0] t_mk, t_adv;
  logic [2:0] t_next;
  logic [29:0] n_inc;
  logic [15:0] n_len;
  logic n_half, n_fs, n_clr;
  logic [1:0] n_mk, n_adv;
  logic [2:0] n_next;
  logic tick, advance, length_done;

  // Length 0 stands for the full 65536 ticks.
  function automatic logic [16:0] len_ticks(input logic [15:0] len);
    len_ticks = (len == 16'h0000) ? 17'h10000 : {1'b0, len};
  endfunction

  seg_table u_cur (
    .ref_clk(ref_clk), .resetn(resetn), .wr_en(cfg_wr_en), .wr_idx(cfg_segment),
    .wr_increment(segment_increment), .wr_length(segment_length),
    .wr_half_rate(segment_half_rate), .wr_fast_settle(segment_fast_settle),
    .wr_marker_bits(segment_marker_bits), .wr_accum_clear(segment_accum_clear),
    .wr_advance_source(segment_advance_source), .wr_successor(segment_successor),
    .rd_idx(seg_r), .rd_increment(t_inc), .rd_length(t_len), .rd_half_rate(t_half),
    .rd_fast_settle(t_fs), .rd_marker_bits(t_mk), .rd_accum_clear(t_clr),
    .rd_advance_source(t_adv), .rd_successor(t_next)
  );

  // A second read port for the segment about to be entered; both copies see every write.
  seg_table u_nxt (
    .ref_clk(ref_clk), .resetn(resetn), .wr_en(cfg_wr_en), .wr_idx(cfg_segment),
    .wr_increment(segment_increment), .wr_length(segment_length),
    .wr_half_rate(segment_half_rate), .wr_fast_settle(segment_fast_settle),
    .wr_marker_bits(segment_marker_bits), .wr_accum_clear(segment_accum_clear),
    .wr_advance_source(segment_advance_source), .wr_successor(segment_successor),
    .rd_idx(rd_idx), .rd_increment(n_inc), .rd_length(n_len), .rd_half_rate(n_half),
    .rd_fast_settle(n_fs), .rd_marker_bits(n_mk), .rd_accum_clear(n_clr),
    .rd_advance_source(n_adv), .rd_successor(n_next)
  );

  // Trigger pins pass three flops; an edge counts once stages two and three agree high.
  always_comb begin
    sa_nxt = {sa_r[1:0], event_source_a};
    sb_nxt = {sb_r[1:0], event_source_b};
    sc_nxt = {sc_r[1:0], event_source_c};
    ev_a_nxt = (sa_r[2:1] == 2'b11) ? 1'b1 : ((sa_r[2:1] == 2'b00) ? 1'b0 : ev_a_r);
    ev_b_nxt = (sb_r[2:1] == 2'b11) ? 1'b1 : ((sb_r[2:1] == 2'b00) ? 1'b0 : ev_b_r);
    ev_c_nxt = (sc_r[2:1] == 2'b11) ? 1'b1 : ((sc_r[2:1] == 2'b00) ? 1'b0 : ev_c_r);
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sa_r <= 3'h0;
      sb_r <= 3'h0;
      sc_r <= 3'h0;
      ev_a_r <= 1'b0;
      ev_b_r <= 1'b0;
      ev_c_r <= 1'b0;
    end else begin
      sa_r <= sa_nxt;
      sb_r <= sb_nxt;
      sc_r <= sc_nxt;
      ev_a_r <= ev_a_nxt;
      ev_b_r <= ev_b_nxt;
      ev_c_r <= ev_c_nxt;
    end
  end

  logic rise_a, rise_b, rise_c;
  assign rise_a = ev_a_nxt & ~ev_a_r;
  assign rise_b = ev_b_nxt & ~ev_b_r;
  assign rise_c = ev_c_nxt & ~ev_c_r;

  assign tick = phase_compare_tick && (pre_r == 1'b0);
  assign length_done = tick && (ticks_r == 17'h00001);

  always_comb begin
    unique case (advance_src_t'(t_adv))
      ADV_LEN: advance = length_done;
      ADV_A: advance = rise_a;
      ADV_B: advance = rise_b;
      ADV_C: advance = rise_c;
    endcase
  end

  assign rd_idx = (state_r == SEQ_IDLE) ? `SEG_FIRST : t_next;

  always_comb begin
    state_nxt = state_r;
    seg_nxt = seg_r;
    ticks_nxt = ticks_r;
    pre_nxt = pre_r;
    acc_nxt = acc_r;
    fs_nxt = fs_r;
    mk_nxt = mk_r;
    unique case (state_r)
      SEQ_IDLE: begin
        fs_nxt = 1'b0;
        if (ramp_run) begin
          state_nxt = SEQ_RUN;
          seg_nxt = rd_idx;
          ticks_nxt = len_ticks(n_len);
          pre_nxt = n_half;
          fs_nxt = n_fs;
          mk_nxt = n_mk;
          if (n_clr) begin
            acc_nxt = 33'h0;
          end
        end
      end
      SEQ_RUN: begin
        if (!ramp_run) begin
          state_nxt = SEQ_IDLE;
          fs_nxt = 1'b0;
        end else begin
          if (phase_compare_tick) begin
            // Half-rate toggles so every other phase-compare cycle is a tick.
            pre_nxt = t_half ? ~pre_r : 1'b0;
          end
          // accumulate signed increment.
          // Once the length is spent an event-driven segment holds until its event arrives.
          if (tick && (ticks_r != 17'h00000)) begin
            acc_nxt = acc_r + {{3{t_inc[29]}}, t_inc};
            ticks_nxt = ticks_r - 17'h00001;
          end
          if (advance) begin
            seg_nxt = rd_idx;
            ticks_nxt = len_ticks(n_len);
            pre_nxt = n_half;
            fs_nxt = n_fs;
            mk_nxt = n_mk;
            if (n_clr) begin
              acc_nxt = 33'h0;
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= SEQ_IDLE;
      seg_r <= `SEG_FIRST;
      ticks_r <= 17'h0;
      pre_r <= 1'b0;
      acc_r <= 33'h0;
      fs_r <= 1'b0;
      mk_r <= 2'h0;
    end else begin
      state_r <= state_nxt;
      seg_r <= seg_nxt;
      ticks_r <= ticks_nxt;
      pre_r <= pre_nxt;
      acc_r <= acc_nxt;
      fs_r <= fs_nxt;
      mk_r <= mk_nxt;
    end
  end

  assign ramp_accum = acc_r;
  assign active_segment = seg_r;
  assign fast_settle_en = fs_r;
  assign marker_out_low = mk_r[0];
  assign marker_out_high = mk_r[1];
endmodule

// ### testbench/ramp_seg_props.sv
// Concurrent checks on the ramp segment sequencer ports.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
module ramp_seg_props (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic ramp_run,
  input wire logic phase_compare_tick,
  input wire logic [32:0] ramp_accum,
  input wire logic [2:0] active_segment,
  input wire logic fast_settle_en,
  input wire logic marker_out_low,
  input wire logic marker_out_high
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  a_reset_zero_out:
    assert property ($rose(resetn) |-> ramp_accum == 33'h0 && !fast_settle_en && !marker_out_low)
    else $error("outputs not zero after reset");
  a_entry_first_seg:
    assert property ($rose(ramp_run) |-> ##[1:2] active_segment == 3'h0)
    else $error("run did not start at segment zero");
  // Entry right after a restart is left out, as its clear can zero the accumulator with no tick while active_segment stays at 0.
  a_accum_cause:
    assert property ($changed(ramp_accum) && $past(ramp_run, 3)
      |-> $past(phase_compare_tick) || $changed(active_segment))
    else $error("accumulator moved without a tick or entry");
  a_idle_hold:
    assert property (!ramp_run ##1 !ramp_run |=> $stable(ramp_accum))
    else $error("accumulator moved while idle");
  a_marker_cause:
    assert property (($changed(marker_out_low) || $changed(marker_out_high)) && $past(ramp_run, 3)
      |-> $changed(active_segment))
    else $error("markers changed outside segment entry");
  a_fast_off_idle:
    assert property (!ramp_run ##1 !ramp_run |=> !fast_settle_en)
    else $error("fast settle held while idle");
  a_fast_rise_run:
    assert property ($rose(fast_settle_en) |-> $past(ramp_run))
    else $error("fast settle rose while idle");
  a_seg_move_run:
    assert property ($changed(active_segment) |-> $past(ramp_run) || active_segment == 3'h0)
    else $error("segment moved while idle");
  c_entry: cover property ($rose(ramp_run));
  c_seg_step: cover property (ramp_run && $changed(active_segment));
  c_fast_on: cover property ($rose(fast_settle_en));
endmodule
bind ramp_segment_control ramp_seg_props u_props (.ref_clk, .resetn, .ramp_run,
  .phase_compare_tick, .ramp_accum, .active_segment, .fast_settle_en, .marker_out_low,
  .marker_out_high);

// ### testbench/ramp_segment_control_bench.sv
// Self-checking bench for the ramp segment sequencer.
// Assumes the core files and the checker are compiled first.
`timescale 1ns/1ps
module ramp_segment_control_bench;
  logic ref_clk = 0, resetn = 0, ramp_run = 0, tick = 0, wr = 0;
  logic hr = 0, fs = 0, clr = 0, fse, mlo, mhi;
  logic [2:0] ev = 3'h0, seg = 3'h0, nxt = 3'h0, act;
  logic [29:0] inc = 30'h0;
  logic [15:0] len = 16'h0;
  logic [1:0] mk = 2'h0, adv = 2'h0;
  logic [32:0] accum;
  int err_count = 0, cmp_count = 0;
  always #12.5 ref_clk = ~ref_clk;
  ramp_segment_control dut (.ref_clk(ref_clk), .resetn(resetn), .ramp_run(ramp_run),
    .phase_compare_tick(tick), .event_source_a(ev[0]), .event_source_b(ev[1]),
    .event_source_c(ev[2]), .cfg_wr_en(wr), .cfg_segment(seg), .segment_increment(inc),
    .segment_length(len), .segment_half_rate(hr), .segment_fast_settle(fs),
    .segment_marker_bits(mk), .segment_accum_clear(clr), .segment_advance_source(adv),
    .segment_successor(nxt), .ramp_accum(accum), .active_segment(act),
    .fast_settle_en(fse), .marker_out_low(mlo), .marker_out_high(mhi));
  task automatic chk(input string nm, input logic [32:0] exp, input logic [32:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // The argument fm packs fast settle then the two marker bits.
  task automatic outs(input logic [2:0] s, input logic [32:0] a, input logic [2:0] fm);
    @(negedge ref_clk);
    chk("active_segment", 33'(s), 33'(act));
    chk("ramp_accum", a, accum);
    chk("fast_settle_en", 33'(fm[2]), 33'(fse));
    chk("markers", 33'(fm[1:0]), {31'h0, mhi, mlo});
    @(posedge ref_clk);
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge ref_clk) tick <= 1'b1;
    @(posedge ref_clk) tick <= 1'b0;
  endtask
  // Field pack f is half rate, fast settle, markers, clear, advance, successor.
  task automatic wseg(input logic [2:0] s, input logic [29:0] i, input logic [15:0] l,
      input logic [9:0] f);
    @(posedge ref_clk);
    wr <= 1'b1;
    seg <= s;
    inc <= i;
    len <= l;
    {hr, fs, mk, clr, adv, nxt} <= f;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  // Trigger pins are synchronised, so the event is held a few cycles and given time.
  task automatic pulse(input logic [2:0] e);
    ev <= e;
    repeat (3) @(posedge ref_clk);
    ev <= 3'h0;
    repeat (8) @(posedge ref_clk);
  endtask
  task automatic zero_table;
    @(posedge ref_clk);
    outs(3'h0, 33'h0, 3'h0);
    ramp_run <= 1'b1;
    repeat (3) @(posedge ref_clk);
    outs(3'h0, 33'h0, 3'h0);
    ticks(3);
    outs(3'h0, 33'h0, 3'h0);
  endtask
  task automatic pattern(input logic [1:0] k);
    ramp_run <= 1'b0;
    wseg(3'h3, 30'h1, 16'h2, {5'h06, k, 3'h0});
    ramp_run <= 1'b1;
    repeat (3) @(posedge ref_clk);
    outs(3'h0, 33'h0, 3'h5);
    ticks(3);
    outs(3'h1, 33'h00000000f, 3'h3);
    ticks(2);
    outs(3'h2, 33'h00000000b, 3'h0);
    ticks(2);
    outs(3'h2, 33'h00000000c, 3'h0);
    // The half-rate prescaler again skips the first phase-compare cycle, as it toggles on each one.
    ticks(2);
    outs(3'h3, 33'h00000000d, 3'h3);
    ticks(4);
    outs(3'h3, 33'h00000000f, 3'h3);
    pulse(3'h1 << (k % 3));
    outs(3'h3, 33'h00000000f, 3'h3);
    pulse(3'h1 << (k - 2'h1));
    outs(3'h0, 33'h0, 3'h5);
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    zero_table();
    // clear set on the first segment
    wseg(3'h0, 30'h5, 16'h3, 10'h161);
    wseg(3'h1, 30'h3ffffffe, 16'h2, 10'h0c2);
    wseg(3'h2, 30'h1, 16'h2, 10'h203);
    for (int k = 1; k < 4; k++) begin
      pattern(2'(k));
    end
    conclude();
  end
  initial begin
    repeat (4000) @(posedge ref_clk);
    err_count++;
    conclude();
  end
endmodule
